/* src/rdec_pkg.sv */
// Function
// - automatic mode measures host transmit bit time and drives transmitter enable from it
// - automatic mode assumes 1200 bit/s at slowest and ten-bit characters
// - request-to-send mode drives transmitter enable straight from host rts
// - data-driven mode enables the transmitter while host transmit data is 0
// - data-driven mode releases the transmitter while host transmit data is 1
// - mode switch is sampled exactly once after reset, then that mode runs
// - later mode switch changes are ignored until the next reset
// - always mode keeps transmitter enabled and lights the enable indicator
// - sampling of incoming serial data outranks every other task
// - host rts is returned to the host as cts
// - host dtr is returned to the host as both dcd and dsr
// - automatic mode releases within 4, 10 or 20 bit times by detected rate
// - with echo off, own transmitted characters are not returned as receive data
package rdec_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MIN_BAUD = 1200;
  localparam int unsigned CHAR_BITS = 10;
  localparam int unsigned BAUD_38K = 38400;
  localparam int unsigned BAUD_57K = 57600;
  localparam int unsigned BAUD_115K = 115200;
  // longest bit time in cycles at the slowest rate
  localparam int unsigned BIT_MAX_CYC = CLK_HZ / MIN_BAUD;
  // rate class boundaries, halfway between neighbouring standard bit times
  localparam int unsigned THR_SLOW = (CLK_HZ / BAUD_38K + CLK_HZ / BAUD_57K) / 2;
  localparam int unsigned THR_MID = (CLK_HZ / BAUD_57K + CLK_HZ / BAUD_115K) / 2;
  localparam logic [4:0] TURN_BITS_SLOW = 5'h04;
  localparam logic [4:0] TURN_BITS_MID = 5'h0a;
  localparam logic [4:0] TURN_BITS_FAST = 5'h14;
  localparam int CNT_W = 24;
  localparam int TURN_W = CNT_W + 5;
  localparam int FIFO_DEPTH = 4;
  // mode switch codes
  localparam logic [1:0] MODE_ALWAYS = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_RTS = 2'h2;
  localparam logic [1:0] MODE_DATA = 2'h3;
  localparam int ECHO_OFF_BIT = 5;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_MEAS = 8'h0c;
  localparam int CTRL_MEAS_EN = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LOADED = 2;
  localparam int ST_TX_EN = 3;
  localparam int ST_BAUD_OK = 4;
  localparam int ST_LEVEL_LSB = 5;
  localparam int ST_FULL = 8;
  typedef enum logic {AB_IDLE, AB_HOLD} rdec_ab_t;
endpackage : rdec_pkg

/* src/rdec_fifo.sv */
`timescale 1ns/1ps
module rdec_fifo #(
  parameter int W = 24,
  parameter int D = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int PW = $clog2(D);
  localparam int LW = $clog2(D+1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [LW-1:0] cnt;
  } rdec_fifo_st_t;
  rdec_fifo_st_t s_r;
  rdec_fifo_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != LW'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == PW'(D-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == PW'(D-1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : rdec_fifo

/* src/rdec_top.sv */
`timescale 1ns/1ps
module rdec_top #(
  parameter int unsigned BIT_MAX = rdec_pkg::BIT_MAX_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic host_txd,
  input wire logic host_rts,
  input wire logic host_dtr,
  input wire logic line_rxd,
  input wire logic [1:0] mode_select_switch,
  input wire logic [5:0] line_config_switch,
  output logic host_rxd,
  output logic host_cts,
  output logic host_dcd,
  output logic host_dsr,
  output logic host_ri,
  output logic line_txd,
  output logic line_tx_en,
  output logic tx_en_led
);
  localparam int CW = rdec_pkg::CNT_W;
  localparam int TW = rdec_pkg::TURN_W;
  localparam int LW = $clog2(rdec_pkg::FIFO_DEPTH + 1);

  typedef struct packed {
    logic loaded;
    logic [1:0] mode;
    rdec_pkg::rdec_ab_t ab;
    logic txd_q;
    logic [CW-1:0] low_cnt;
    logic [TW-1:0] idle_cnt;
    logic [CW-1:0] period;
    logic baud_ok;
    logic meas_vld;
    logic [CW-1:0] meas;
    logic meas_en;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic resp;
    logic rxd;
    logic cts;
    logic dcd;
    logic dsr;
    logic ri;
    logic txd;
    logic tx_en;
  } rdec_st_t;

  rdec_st_t s_r;
  rdec_st_t s_nxt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [CW-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic addr_ok;
  logic [TW-1:0] turn_cyc;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
    return (a[7:0] == off) && (a[31:8] == '0);
  endfunction : is_reg

  // turnaround window in cycles for a measured bit time
  function automatic logic [TW-1:0] turn_cycles(input logic [CW-1:0] per);
    logic [4:0] bits;
    bits = rdec_pkg::TURN_BITS_FAST;
    if (per > CW'(rdec_pkg::THR_SLOW)) begin
      bits = rdec_pkg::TURN_BITS_SLOW;
    end else if (per > CW'(rdec_pkg::THR_MID)) begin
      bits = rdec_pkg::TURN_BITS_MID;
    end
    return TW'(bits) * TW'(per);
  endfunction : turn_cycles

  assign addr_ok = hsel && htrans[1] && hready;
  assign fifo_pop = addr_ok && !hwrite && is_reg(haddr, rdec_pkg::ADDR_MEAS);
  assign turn_cyc = turn_cycles(s_r.period);

  // ----------------------------------------------------------------
  // measurement queue
  // ----------------------------------------------------------------
  rdec_fifo #(
    .W(CW),
    .D(rdec_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(s_r.meas_vld),
    .in_ready(fifo_in_ready),
    .in_data(s_r.meas),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic mode_en;
    s_nxt = s_r;
    rise = host_txd && !s_r.txd_q;
    mode_en = 1'b0;
    // strap-like capture, once, on the first edge after reset release
    if (!s_r.loaded) begin
      s_nxt.loaded = 1'b1;
      s_nxt.mode = mode_select_switch;
    end
    // no path rewrites mode once loaded, so switch moves are ignored
    // serial sampling runs every cycle, unconditionally, ahead of the bus
    s_nxt.txd_q = host_txd;
    s_nxt.low_cnt = host_txd ? '0 : (&s_r.low_cnt ? s_r.low_cnt : s_r.low_cnt + 1'b1);
    // shortest low run seen is one bit time; never slower than the floor rate
    if (rise && s_r.low_cnt != '0 && s_r.low_cnt < s_r.period) begin
      s_nxt.period = s_r.low_cnt;
      s_nxt.baud_ok = 1'b1;
      if (s_r.meas_en && !s_r.meas_vld) begin
        s_nxt.meas_vld = 1'b1;
        s_nxt.meas = s_r.low_cnt;
      end
    end
    // a pending measurement waits for room rather than being overwritten
    if (s_r.meas_vld && fifo_in_ready) begin
      s_nxt.meas_vld = 1'b0;
    end
    // automatic turnaround
    case (s_r.ab)
      rdec_pkg::AB_IDLE: begin
        s_nxt.idle_cnt = '0;
        if (s_r.loaded && s_r.mode == rdec_pkg::MODE_AUTO && !host_txd) begin
          s_nxt.ab = rdec_pkg::AB_HOLD;
        end
      end
      rdec_pkg::AB_HOLD: begin
        if (!host_txd) begin
          s_nxt.idle_cnt = '0;
        end else if (s_r.idle_cnt + 1'b1 >= turn_cyc) begin
          s_nxt.ab = rdec_pkg::AB_IDLE;
          s_nxt.idle_cnt = '0;
        end else begin
          s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
        end
      end
      default: begin
        s_nxt.ab = rdec_pkg::AB_IDLE;
      end
    endcase
    // enable source per mode
    case (s_r.mode)
      rdec_pkg::MODE_ALWAYS: mode_en = 1'b1;
      rdec_pkg::MODE_AUTO: mode_en = (s_nxt.ab == rdec_pkg::AB_HOLD);
      rdec_pkg::MODE_RTS: mode_en = host_rts;
      rdec_pkg::MODE_DATA: mode_en = !host_txd;
      default: mode_en = 1'b0;
    endcase
    s_nxt.tx_en = s_r.loaded && mode_en;
    s_nxt.txd = host_txd;
    // with echo off, while our own driver is on, the looped-back line is masked to idle
    s_nxt.rxd = (line_config_switch[rdec_pkg::ECHO_OFF_BIT] && s_r.tx_en) ? 1'b1
      : line_rxd;
    s_nxt.cts = host_rts;
    s_nxt.dcd = host_dtr;
    s_nxt.dsr = host_dtr;
    s_nxt.ri = 1'b0;
    // bus: write data arrives one cycle after its address
    s_nxt.resp = 1'b0;
    if (s_r.wr_pend && s_r.wr_addr == rdec_pkg::ADDR_CTRL) begin
      s_nxt.meas_en = hwdata[rdec_pkg::CTRL_MEAS_EN];
    end
    s_nxt.wr_pend = addr_ok && hwrite;
    s_nxt.wr_addr = haddr[31:8] == '0 ? haddr[7:0] : 8'hff;
    s_nxt.rdata = '0;
    if (addr_ok && !hwrite) begin
      if (is_reg(haddr, rdec_pkg::ADDR_CTRL)) begin
        s_nxt.rdata[rdec_pkg::CTRL_MEAS_EN] = s_r.meas_en;
      end else if (is_reg(haddr, rdec_pkg::ADDR_STATUS)) begin
        s_nxt.rdata[rdec_pkg::ST_MODE_LSB +: 2] = s_r.mode;
        s_nxt.rdata[rdec_pkg::ST_LOADED] = s_r.loaded;
        s_nxt.rdata[rdec_pkg::ST_TX_EN] = s_r.tx_en;
        s_nxt.rdata[rdec_pkg::ST_BAUD_OK] = s_r.baud_ok;
        s_nxt.rdata[rdec_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
        s_nxt.rdata[rdec_pkg::ST_FULL] = !fifo_in_ready;
      end else if (is_reg(haddr, rdec_pkg::ADDR_PERIOD)) begin
        s_nxt.rdata[CW-1:0] = s_r.period;
      end else if (is_reg(haddr, rdec_pkg::ADDR_MEAS)) begin
        s_nxt.rdata[CW-1:0] = fifo_out_valid ? fifo_out_data : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.period <= CW'(BIT_MAX);
      s_r.meas_en <= rdec_pkg::CTRL_RESET;
      s_r.txd_q <= 1'b1;
      s_r.txd <= 1'b1;
      s_r.rxd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = s_r.resp;
  assign hrdata = s_r.rdata;
  assign host_rxd = s_r.rxd;
  assign host_cts = s_r.cts;
  assign host_dcd = s_r.dcd;
  assign host_dsr = s_r.dsr;
  assign host_ri = s_r.ri;
  assign line_txd = s_r.txd;
  assign line_tx_en = s_r.tx_en;
  assign tx_en_led = s_r.tx_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_always_enabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded && s_r.mode == rdec_pkg::MODE_ALWAYS |=> line_tx_en && tx_en_led)
    else $error("always mode dropped enable");
  a_rts_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded && s_r.mode == rdec_pkg::MODE_RTS |=> line_tx_en == $past(host_rts))
    else $error("enable does not follow rts");
  a_data_low_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded && s_r.mode == rdec_pkg::MODE_DATA && !host_txd |=> line_tx_en)
    else $error("data low did not enable");
  a_data_high_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded && s_r.mode == rdec_pkg::MODE_DATA && host_txd |=> !line_tx_en)
    else $error("data high did not release");
  a_mode_held: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded |=> s_r.loaded && $stable(s_r.mode))
    else $error("mode changed after load");
  a_mode_loaded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !s_r.loaded |=> s_r.loaded && s_r.mode == $past(mode_select_switch))
    else $error("mode not captured once");
  a_cts_dtr_loop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 host_cts == $past(host_rts) && host_dcd == $past(host_dtr)
      && host_dsr == $past(host_dtr))
    else $error("modem loopback wrong");
  a_ring_idle: assert property (
    @(posedge hclk) disable iff (!hresetn) !host_ri)
    else $error("ring indicator active");
  a_echo_mask: assert property (
    @(posedge hclk) disable iff (!hresetn)
    line_config_switch[rdec_pkg::ECHO_OFF_BIT] && line_tx_en |=> host_rxd)
    else $error("own data echoed");
  a_auto_start: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.loaded && s_r.mode == rdec_pkg::MODE_AUTO && !host_txd |=> line_tx_en)
    else $error("start bit did not enable");
  a_auto_release: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.ab == rdec_pkg::AB_HOLD |-> s_r.idle_cnt < turn_cyc)
    else $error("turnaround window exceeded");
  a_period_floor: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_r.period <= CW'(BIT_MAX) && s_r.period != '0)
    else $error("bit time outside range");
endmodule : rdec_top

/* dv/rdec_host_uart.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host transmit side: sends one ten-bit character per go
// ----------------------------------------
module rdec_host_uart (
  input wire logic hclk,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic [15:0] bit_cyc,
  output logic host_txd,
  output logic busy
);
  logic [9:0] frame;
  initial begin
    host_txd = 1'b1;
    busy = 1'b0;
  end
  always begin
    @(posedge hclk);
    if (go === 1'b1) begin
      busy <= 1'b1;
      // start, eight data bits lsb first, stop; never slower than 1200 bit/s
      frame = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
        host_txd <= frame[i];
        repeat (bit_cyc) @(posedge hclk);
      end
      busy <= 1'b0;
    end
  end
endmodule : rdec_host_uart

/* dv/rdec_top_tb_top.sv */
`timescale 1ns/1ps
module rdec_top_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, host_rxd, host_cts, host_dcd, host_dsr, host_ri;
  logic line_txd, line_tx_en, tx_en_led, host_txd, busy, prev;
  logic [31:0] hrdata, rd;
  logic host_rts = 1'b0;
  logic host_dtr = 1'b0;
  logic line_rxd = 1'b1;
  logic go = 1'b0;
  logic [1:0] mode_sw = 2'h0;
  logic [5:0] cfg_sw = 6'h0;
  logic [7:0] ch = 8'h00;
  logic [15:0] bit_cyc = 16'h0010;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  // ----------------------------------------
  // design, host model and clock
  // ----------------------------------------
  // short slowest bit time keeps the run brief
  rdec_top #(.BIT_MAX(2000)) i_rdec_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .host_txd(host_txd), .host_rts(host_rts), .host_dtr(host_dtr), .line_rxd(line_rxd),
    .mode_select_switch(mode_sw), .line_config_switch(cfg_sw), .host_rxd(host_rxd),
    .host_cts(host_cts), .host_dcd(host_dcd), .host_dsr(host_dsr), .host_ri(host_ri),
    .line_txd(line_txd), .line_tx_en(line_tx_en), .tx_en_led(tx_en_led));
  rdec_host_uart i_rdec_host_uart (.hclk(hclk), .go(go), .data(ch), .bit_cyc(bit_cyc),
    .host_txd(host_txd), .busy(busy));
  initial begin
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task print_verdict;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : ahb
  task do_reset(input logic [1:0] m);
    hresetn <= 1'b0;
    mode_sw <= m;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : do_reset
  task send_char(input logic [7:0] c);
    ch <= c;
    go <= 1'b1;
    repeat (2) @(posedge hclk);
    go <= 1'b0;
    while (busy === 1'b1) @(posedge hclk);
  endtask : send_char
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_always;
    do_reset(rdec_pkg::MODE_ALWAYS);
    host_dtr <= 1'b1;
    line_rxd <= 1'b0;
    cfg_sw <= 6'h20;
    mode_sw <= rdec_pkg::MODE_DATA;
    repeat (3) @(posedge hclk);
    chk({line_tx_en, tx_en_led}, 32'h3);
    chk({host_dcd, host_dsr, host_ri, host_rxd}, 32'hd);
    host_dtr <= 1'b0;
    cfg_sw <= 6'h00;
    repeat (2) @(posedge hclk);
    chk({host_dcd, host_dsr, host_rxd}, 32'h0);
    ahb(1'b0, rdec_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h7, 32'h4);
    line_rxd <= 1'b1;
  endtask : t_always
  task t_rts;
    do_reset(rdec_pkg::MODE_RTS);
    host_rts <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({line_tx_en, host_cts}, 32'h3);
    host_rts <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({line_tx_en, host_cts}, 32'h0);
  endtask : t_rts
  task t_data;
    do_reset(rdec_pkg::MODE_DATA);
    ch <= 8'h35;
    bit_cyc <= 16'h0003;
    go <= 1'b1;
    prev = 1'b1;
    repeat (40) begin
      @(posedge hclk);
      go <= 1'b0;
      chk({line_txd, line_tx_en, tx_en_led}, {29'h0, prev, ~prev, ~prev});
      prev = host_txd;
    end
  endtask : t_data
  task t_auto;
    do_reset(rdec_pkg::MODE_AUTO);
    ahb(1'b1, rdec_pkg::ADDR_CTRL, 32'h1, rd);
    ahb(1'b0, rdec_pkg::ADDR_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    // shrinking bit times make every low run a new minimum
    for (int i = 0; i < 5; i++) begin
      bit_cyc <= 16'(17 - i);
      send_char(8'h00);
      chk(line_tx_en, 32'h1);
    end
    n = 0;
    while (line_tx_en === 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    chk(n >= 2310 && n <= 2345, 32'h1);
    ahb(1'b0, rdec_pkg::ADDR_PERIOD, 32'h0, rd);
    chk(rd, 32'd117);
    ahb(1'b0, rdec_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'hffffffef, 32'h185);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, rdec_pkg::ADDR_MEAS, 32'h0, rd);
      chk(rd, 32'(153 - 9 * i));
    end
    ahb(1'b0, rdec_pkg::ADDR_MEAS, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, rdec_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h1e0, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
  endtask : t_auto
  initial begin
    t_always;
    t_rts;
    t_data;
    t_auto;
    print_verdict();
  end
endmodule : rdec_top_tb_top
